// ==== include/hscp_pkg.sv ====
// shared constants for the host serial config parser
package hscp_pkg;
	// frame bytes and message types
	localparam logic [7:0] SOF = 8'h01, EOF = 8'h04, OVH = 8'h05;
	localparam logic [7:0] T_PAN = 8'h01, T_ADDR = 8'h03, T_CHAN = 8'h05, T_RXALL = 8'h07;
	localparam logic [7:0] T_ACKEN = 8'h09, T_PWR = 8'h0F, T_IO = 8'h1E, T_SLP = 8'h1F;
	localparam logic [7:0] T_ADC = 8'h20, T_DBG = 8'h27, T_LED = 8'h28, T_BAUD = 8'h29;
	localparam logic [7:0] T_SAVE = 8'h11, T_RESET = 8'h18, T_RFRX = 8'h95, T_RFALL = 8'hA9;
	localparam logic [7:0] ACK_FLAG = 8'h80;
	localparam int MAXPAY = 16;
	// byte positions in the configuration image
	localparam int NCFG = 36;
	localparam logic [5:0] O_PAN = 6'h00, O_LONG = 6'h02, O_SHORT = 6'h0A, O_CHAN = 6'h0C;
	localparam logic [5:0] O_RXALL = 6'h0D, O_ACKEN = 6'h0E, O_PWR = 6'h0F, O_IO = 6'h10;
	localparam logic [5:0] O_SLP = 6'h16, O_ADC = 6'h1C, O_DBG = 6'h20, O_LED = 6'h21;
	localparam logic [5:0] O_BAUD = 6'h22;
	localparam logic [15:0] SH_LONG = 16'hFFFE, SH_BCAST = 16'hFFFF;
	// led byte fields
	localparam int LED_HB = 0, LED_SER = 1, LED_RF = 2, LED_PAIR = 7;
	// register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00, A_STAT = 8'h04, A_IO = 8'h08, A_IOIN = 8'h0C;
	localparam logic [7:0] A_RF = 8'h10, A_ADC = 8'h14;
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int HB_MS = 2000, FLASH_MS = 20;
	localparam int HB_CYC = CLK_HZ / 1000 * HB_MS;
	localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
	localparam int BAUD_DEF = 115_200, BAUD_MIN = 1_200;
	localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF);
	localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BAUD_MIN);
	localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BAUD_DEF);
	localparam logic [15:0] ADC_BASE = 16'h0040;
	localparam logic [1:0] MAX_RETRY = 2'h3;

	typedef struct packed {logic ok; logic [5:0] off; logic [4:0] n;} hscp_slot_t;

	// where a setting message lands in the image
	function automatic hscp_slot_t hscp_slot(input logic [7:0] t);
		unique case (t)
			T_PAN:   return '{1'b1, O_PAN, 5'h02};
			T_ADDR:  return '{1'b1, O_LONG, 5'h0A};
			T_CHAN:  return '{1'b1, O_CHAN, 5'h01};
			T_RXALL: return '{1'b1, O_RXALL, 5'h01};
			T_ACKEN: return '{1'b1, O_ACKEN, 5'h01};
			T_PWR:   return '{1'b1, O_PWR, 5'h01};
			T_IO:    return '{1'b1, O_IO, 5'h06};
			T_SLP:   return '{1'b1, O_SLP, 5'h06};
			T_ADC:   return '{1'b1, O_ADC, 5'h04};
			T_DBG:   return '{1'b1, O_DBG, 5'h01};
			T_LED:   return '{1'b1, O_LED, 5'h01};
			T_BAUD:  return '{1'b1, O_BAUD, 5'h02};
			default: return '{1'b0, 6'h00, 5'h00};
		endcase
	endfunction : hscp_slot
endpackage : hscp_pkg

// ==== design/hscp_top.sv ====
// serial frame parser, configuration store and pin control
`timescale 1ns/10ps

module hscp_sync #(parameter int W = 1) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q, s2_q, s3_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			q    <= '1;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// a bit counts only once two stages agree
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) q[i] <= s3_q[i];
			end
		end
	end
endmodule : hscp_sync

module hscp_top import hscp_pkg::*; #(
	parameter int HB_CYCLES    = HB_CYC,
	parameter int FLASH_CYCLES = FLASH_CYC
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// serial link to the host controller
	input  wire logic        ser_rxd,
	output logic             ser_txd,
	// nonvolatile byte store
	output logic             nvm_req,
	output logic             nvm_we,
	output logic      [5:0]  nvm_addr,
	output logic      [7:0]  nvm_wdata,
	input  wire logic [7:0]  nvm_rdata,
	input  wire logic        nvm_ack,
	// radio settings and traffic
	output logic      [15:0] rf_pan,
	output logic      [15:0] rf_short,
	output logic      [63:0] rf_long,
	output logic             rf_use_long,
	output logic      [7:0]  rf_channel,
	output logic      [4:0]  rf_power,
	output logic             rf_ack_en,
	output logic             rf_rx_all,
	output logic             rf_tx_req,
	input  wire logic        rf_tx_done,
	input  wire logic        rf_tx_acked,
	input  wire logic        rf_rx_valid,
	input  wire logic [15:0] rf_rx_pan,
	input  wire logic [7:0]  rf_rx_data,
	// user pins
	input  wire logic [11:0] io_in,
	output logic      [11:0] io_out,
	output logic      [11:0] io_oe,
	output logic      [11:0] io_pull,
	output logic             sleeping,
	// mode pins carrying debug signals
	input  wire logic [2:0]  mode_in,
	output logic      [2:0]  mode_out,
	output logic      [2:0]  mode_oe,
	// analog converter control
	output logic             adc_start,
	output logic      [7:0]  adc_ref,
	output logic      [7:0]  adc_res,
	output logic      [7:0]  adc_avg
);
	if (HB_CYCLES < 4 || FLASH_CYCLES < 2 || FLASH_CYCLES >= HB_CYCLES) begin : g_chk
		$error("hscp_top: bad timing parameters");
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic        rxd_s;
	logic [11:0] io_s;
	logic [2:0]  mode_s;
	hscp_sync #(.W(1))  u_rx (.hclk(hclk), .hresetn(hresetn), .d(ser_rxd), .q(rxd_s));
	hscp_sync #(.W(12)) u_io (.hclk(hclk), .hresetn(hresetn), .d(io_in), .q(io_s));
	hscp_sync #(.W(3))  u_md (.hclk(hclk), .hresetn(hresetn), .d(mode_in), .q(mode_s));

	// ----------------------------------------------------------------
	// working configuration image
	// ----------------------------------------------------------------
	logic [7:0]  cfg_q [NCFG];
	wire  [15:0] div_raw = {cfg_q[O_BAUD+1], cfg_q[O_BAUD]};
	wire         div_ok  = div_raw >= DIV_MIN && div_raw <= DIV_MAX;
	wire  [15:0] div     = div_ok ? div_raw : DIV_DEF;
	wire  [15:0] shrt    = {cfg_q[O_SHORT+1], cfg_q[O_SHORT]};
	wire  [15:0] pan     = {cfg_q[O_PAN+1], cfg_q[O_PAN]};
	wire         rxall   = cfg_q[O_RXALL][0];
	wire         acken   = cfg_q[O_ACKEN][0];
	wire  [7:0]  led     = cfg_q[O_LED];

	// ----------------------------------------------------------------
	// serial receiver
	// ----------------------------------------------------------------
	logic [15:0] rcnt_q;
	logic [3:0]  rbit_q;
	logic [8:0]  rsh_q;
	logic        rbusy_q, rvld_q;
	wire         r_tick = rcnt_q == 16'h0000;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rcnt_q  <= 16'h0000;
			rbit_q  <= 4'h0;
			rsh_q   <= 9'h000;
			rbusy_q <= 1'b0;
			rvld_q  <= 1'b0;
		end else begin
			rvld_q <= 1'b0;
			if (!rbusy_q) begin
				if (!rxd_s) begin
					rbusy_q <= 1'b1;
					rbit_q  <= 4'h0;
					rcnt_q  <= div >> 1;
				end
			end else if (!r_tick) begin
				rcnt_q <= rcnt_q - 16'h0001;
			end else begin
				rcnt_q <= div - 16'h0001;
				rsh_q  <= {rxd_s, rsh_q[8:1]};
				rbit_q <= rbit_q + 4'h1;
				if (rbit_q == 4'h0 && rxd_s) rbusy_q <= 1'b0;
				if (rbit_q == 4'h9) begin
					rbusy_q <= 1'b0;
					rvld_q  <= rxd_s;
				end
			end
		end
	end
	// start bit has left the shifter, stop bit sits on top
	wire [7:0] rbyte = rsh_q[7:0];

	// ----------------------------------------------------------------
	// frame parser
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		P_DUP = 7'h01, P_SOF = 7'h02, P_LEN = 7'h04, P_TYP = 7'h08,
		P_PAY = 7'h10, P_SUM = 7'h20, P_EOF = 7'h40
	} hscp_pst_t;
	hscp_pst_t  p_q;
	logic [7:0] plen_q, ptyp_q, psum_q;
	logic [4:0] pcnt_q;
	logic       sumok_q, fok_q, fbad_q;
	logic [7:0] pbuf_q [MAXPAY];
	wire  [7:0] npay   = plen_q - OVH;
	wire        len_ok = rbyte == plen_q && rbyte >= OVH && rbyte <= OVH + 8'(MAXPAY);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p_q <= P_DUP;
			{plen_q, ptyp_q, psum_q, pcnt_q} <= '0;
			{sumok_q, fok_q, fbad_q} <= '0;
		end else begin
			fok_q  <= 1'b0;
			fbad_q <= 1'b0;
			if (rvld_q) begin
				unique case (p_q)
					P_DUP: begin
						plen_q <= rbyte;
						p_q    <= P_SOF;
					end
					P_SOF: begin
						psum_q <= rbyte;
						p_q    <= rbyte == SOF ? P_LEN : P_DUP;
						fbad_q <= rbyte != SOF;
					end
					P_LEN: begin
						psum_q <= psum_q + rbyte;
						p_q    <= len_ok ? P_TYP : P_DUP;
						fbad_q <= !len_ok;
					end
					P_TYP: begin
						ptyp_q <= rbyte;
						psum_q <= psum_q + rbyte;
						pcnt_q <= 5'h00;
						p_q    <= plen_q == OVH ? P_SUM : P_PAY;
					end
					P_PAY: begin
						pbuf_q[pcnt_q[3:0]] <= rbyte;
						psum_q <= psum_q + rbyte;
						pcnt_q <= pcnt_q + 5'h01;
						if (8'(pcnt_q) + 8'h01 == npay) p_q <= P_SUM;
					end
					P_SUM: begin
						sumok_q <= rbyte == psum_q;
						p_q     <= P_EOF;
					end
					P_EOF: begin
						fok_q  <= rbyte == EOF && sumok_q;
						fbad_q <= !(rbyte == EOF && sumok_q);
						p_q    <= P_DUP;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// command engine with nonvolatile load and save
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		E_LOAD = 4'h1, E_IDLE = 4'h2, E_SAVE = 4'h4, E_ACK = 4'h8
	} hscp_est_t;
	hscp_est_t  e_q;
	logic [5:0] ptr_q;
	logic       ackp_q, rstp_q, savp_q, liveld_q, tx_act_q;
	logic [7:0] good_q, bad_q;
	hscp_slot_t slot;
	assign slot = hscp_slot(ptyp_q);
	wire take   = e_q == E_IDLE && fok_q;
	wire setok  = take && slot.ok && npay == 8'(slot.n);
	wire nv_fin = nvm_ack && ptr_q == 6'(NCFG - 1);
	wire ack_go = e_q == E_ACK && !tx_act_q;
	logic sw_rst, sw_sav;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			e_q <= E_LOAD;
			{ptr_q, ackp_q, rstp_q, savp_q, liveld_q} <= '0;
			{good_q, bad_q} <= '0;
		end else begin
			liveld_q <= 1'b0;
			// a request landing on its own clear still wins
			rstp_q <= sw_rst || (rstp_q && e_q != E_IDLE);
			savp_q <= sw_sav || (savp_q && !(e_q == E_IDLE && !rstp_q));
			if (fbad_q) bad_q <= bad_q + 8'h01;
			unique case (e_q)
				E_LOAD, E_SAVE: if (nvm_ack) begin
					ptr_q <= ptr_q + 6'h01;
					if (nv_fin) begin
						ptr_q    <= 6'h00;
						liveld_q <= e_q == E_LOAD;
						e_q      <= ackp_q ? E_ACK : E_IDLE;
					end
				end
				E_IDLE: begin
					ackp_q <= 1'b0;
					if (take && ptyp_q == T_RESET) begin
						ackp_q <= 1'b1;
						e_q    <= E_LOAD;
					end else if (take && ptyp_q == T_SAVE) begin
						ackp_q <= 1'b1;
						e_q    <= E_SAVE;
					end else if (setok) begin
						e_q <= E_ACK;
					end else if (rstp_q) begin
						e_q <= E_LOAD;
					end else if (savp_q) begin
						e_q <= E_SAVE;
					end
					if (take && (ptyp_q == T_RESET || ptyp_q == T_SAVE || setok))
						good_q <= good_q + 8'h01;
				end
				E_ACK: if (ack_go) begin
					ackp_q <= 1'b0;
					e_q    <= E_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NCFG; i++) cfg_q[i] <= 8'h00;
		end else begin
			for (int i = 0; i < NCFG; i++) begin
				// setting messages touch only the working copy
				if (setok && i >= int'(slot.off) && i < int'(slot.off) + int'(slot.n))
					cfg_q[i] <= pbuf_q[4'(i - int'(slot.off))];
			end
			if (e_q == E_LOAD && nvm_ack) cfg_q[ptr_q] <= nvm_rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{nvm_req, nvm_we, nvm_addr, nvm_wdata} <= '0;
		end else begin
			nvm_req   <= (e_q == E_LOAD || e_q == E_SAVE) && !nv_fin;
			nvm_we    <= e_q == E_SAVE;
			nvm_addr  <= nvm_ack ? ptr_q + 6'h01 : ptr_q;
			nvm_wdata <= cfg_q[nvm_ack ? ptr_q + 6'h01 : ptr_q];
		end
	end

	// ----------------------------------------------------------------
	// frame transmitter: acknowledge first, then forwarded radio data
	// ----------------------------------------------------------------
	logic [2:0]  tidx_q;
	logic [7:0]  ttyp_q, tpay_q;
	logic        tpl_q, fwdp_q, fwd_typ_q;
	logic [7:0]  fwd_q;
	logic [15:0] tcnt_q;
	logic [9:0]  tsh_q;
	logic [3:0]  tbit_q;
	wire  [7:0]  tlen = tpl_q ? OVH + 8'h01 : OVH;
	wire  [7:0]  tsum = SOF + tlen + ttyp_q + (tpl_q ? tpay_q : 8'h00);
	wire  [2:0]  tlast = tpl_q ? 3'h6 : 3'h5;
	logic [7:0]  tbyte;
	always_comb begin
		unique case (tidx_q)
			3'h0:    tbyte = tlen;
			3'h1:    tbyte = SOF;
			3'h2:    tbyte = tlen;
			3'h3:    tbyte = ttyp_q;
			default: tbyte = (tidx_q == 3'h4 && tpl_q) ? tpay_q
			                 : (tidx_q == tlast ? EOF : tsum);
		endcase
	end
	wire u_idle  = tbit_q == 4'h0;
	wire t_load  = tx_act_q && u_idle;
	wire fwd_go  = fwdp_q && !tx_act_q && !ack_go;
	wire rf_pan_ok = rf_rx_pan == pan;
	wire rf_take = rf_rx_valid && rf_pan_ok;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{tidx_q, ttyp_q, tpay_q, tpl_q, tx_act_q} <= '0;
			{fwdp_q, fwd_typ_q, fwd_q} <= '0;
		end else begin
			if (rf_take) begin
				fwd_q     <= rf_rx_data;
				fwd_typ_q <= rxall;
			end
			fwdp_q <= rf_take || (fwdp_q && !fwd_go);
			if (ack_go) begin
				ttyp_q   <= ptyp_q | ACK_FLAG;
				tpl_q    <= 1'b0;
				tidx_q   <= 3'h0;
				tx_act_q <= 1'b1;
			end else if (fwd_go) begin
				ttyp_q   <= fwd_typ_q ? T_RFALL : T_RFRX;
				tpay_q   <= fwd_q;
				tpl_q    <= 1'b1;
				tidx_q   <= 3'h0;
				tx_act_q <= 1'b1;
			end else if (t_load) begin
				tidx_q <= tidx_q + 3'h1;
				if (tidx_q == tlast) tx_act_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tcnt_q  <= 16'h0000;
			tsh_q   <= 10'h3FF;
			tbit_q  <= 4'h0;
			ser_txd <= 1'b1;
		end else if (t_load) begin
			tsh_q  <= {1'b1, tbyte, 1'b0};
			tbit_q <= 4'hA;
			tcnt_q <= 16'h0000;
		end else if (!u_idle) begin
			ser_txd <= tsh_q[0];
			tcnt_q  <= tcnt_q + 16'h0001;
			if (tcnt_q == div - 16'h0001) begin
				tcnt_q <= 16'h0000;
				tsh_q  <= {1'b1, tsh_q[9:1]};
				tbit_q <= tbit_q - 4'h1;
			end
		end else begin
			ser_txd <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	logic        wr_q, sleep_q, rf_busy_q, rf_fail_q, adc_busy_q;
	logic [7:0]  wa_q;
	logic [11:0] lvl_q, dir_q;
	logic [1:0]  try_q;
	logic [15:0] adc_q;
	wire  aph    = hsel && htrans[1] && hready;
	wire  wr_ctl = wr_q && wa_q == A_CTRL;
	wire  wr_io  = wr_q && wa_q == A_IO;
	wire  wr_rf  = wr_q && wa_q == A_RF && hwdata[0];
	wire  wr_adc = wr_q && wa_q == A_ADC && hwdata[0];
	assign sw_rst = wr_ctl && hwdata[1];
	assign sw_sav = wr_ctl && hwdata[2];
	wire [31:0] stat = {8'h00, bad_q, good_q, 3'h0, adc_busy_q, rf_fail_q, rf_busy_q,
	                    e_q == E_SAVE, e_q == E_LOAD};
	wire [31:0] rdv  = haddr[7:0] == A_CTRL ? {31'h0, sleep_q}
	                 : haddr[7:0] == A_STAT ? stat
	                 : haddr[7:0] == A_IO   ? {4'h0, dir_q, 4'h0, lvl_q}
	                 : haddr[7:0] == A_IOIN ? {20'h0, io_s}
	                 : haddr[7:0] == A_RF   ? {30'h0, rf_fail_q, rf_busy_q}
	                 : haddr[7:0] == A_ADC  ? {31'h0, adc_busy_q} : 32'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_q, wa_q, hrdata, hresp} <= '0;
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_q      <= aph && hwrite;
			if (aph) wa_q <= haddr[7:0];
			if (aph && !hwrite) hrdata <= haddr[31:8] == 24'h0 ? rdv : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// live pin state, sleep and radio send
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{sleep_q, lvl_q, dir_q} <= '0;
		end else begin
			if (wr_ctl) sleep_q <= hwdata[0];
			if (liveld_q) begin
				dir_q <= {cfg_q[O_IO+1][3:0], cfg_q[O_IO]};
				lvl_q <= {cfg_q[O_IO+5][3:0], cfg_q[O_IO+4]};
			end else if (wr_io && !sleep_q) begin
				// held while asleep so wake returns the pre-sleep state
				lvl_q <= hwdata[11:0];
				dir_q <= hwdata[27:16];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{rf_busy_q, rf_fail_q, try_q, rf_tx_req} <= '0;
		end else begin
			rf_tx_req <= 1'b0;
			if (!rf_busy_q && wr_rf) begin
				rf_fail_q <= rxall;
				if (!rxall) begin
					rf_busy_q <= 1'b1;
					try_q     <= 2'h0;
					rf_tx_req <= 1'b1;
				end
			end else if (rf_busy_q && rf_tx_done) begin
				if (!acken || rf_tx_acked) begin
					rf_busy_q <= 1'b0;
				end else if (try_q != MAX_RETRY && !rxall) begin
					try_q     <= try_q + 2'h1;
					rf_tx_req <= 1'b1;
				end else begin
					rf_busy_q <= 1'b0;
					rf_fail_q <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// converter timing
	// ----------------------------------------------------------------
	wire [7:0] amask = cfg_q[O_ADC+3];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{adc_busy_q, adc_q, adc_start} <= '0;
		end else begin
			adc_start <= 1'b0;
			if (!adc_busy_q && wr_adc && amask != 8'h00) begin
				adc_busy_q <= 1'b1;
				adc_start  <= 1'b1;
				adc_q      <= ADC_BASE << cfg_q[O_ADC+1][2:0];
			end else if (adc_busy_q) begin
				adc_q <= adc_q - 16'h0001;
				if (adc_q == 16'h0001) adc_busy_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// indicators and heartbeat
	// ----------------------------------------------------------------
	logic [31:0] hb_q, frx_q, ftx_q;
	wire hb_hit = hb_q == 32'(HB_CYCLES - 1);
	wire ev_rx  = (led[LED_SER] && rvld_q) || (led[LED_RF] && rf_take);
	wire ev_tx  = (led[LED_SER] && t_load) || (led[LED_RF] && rf_tx_req)
	              || (led[LED_HB] && hb_hit);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{hb_q, frx_q, ftx_q} <= '0;
		end else begin
			hb_q  <= hb_hit ? 32'h0 : hb_q + 32'h1;
			frx_q <= ev_rx ? 32'(FLASH_CYCLES) : (frx_q != 32'h0 ? frx_q - 32'h1 : frx_q);
			ftx_q <= ev_tx ? 32'(FLASH_CYCLES) : (ftx_q != 32'h0 ? ftx_q - 32'h1 : ftx_q);
		end
	end
	wire led_on = led[LED_HB] || led[LED_SER] || led[LED_RF];
	wire [11:0] led_m = !led_on ? 12'h000 : led[LED_PAIR] ? 12'h00C : 12'h003;
	wire [11:0] led_v = led[LED_PAIR] ? {8'h00, ftx_q != 32'h0, frx_q != 32'h0, 2'h0}
	                                  : {10'h000, frx_q != 32'h0, ftx_q != 32'h0};

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	wire [11:0] s_dir  = {cfg_q[O_SLP+1][3:0], cfg_q[O_SLP]};
	wire [11:0] s_pull = {cfg_q[O_SLP+3][3:0], cfg_q[O_SLP+2]};
	wire [11:0] s_lvl  = {cfg_q[O_SLP+5][3:0], cfg_q[O_SLP+4]};
	wire [11:0] n_pull = {cfg_q[O_IO+3][3:0], cfg_q[O_IO+2]};
	wire [11:0] ana    = {4'h0, amask};
	// sleep settings apply to analog pins too
	wire [11:0] oe_d   = sleep_q ? s_dir : (dir_q & ~ana) | led_m;
	wire [11:0] out_d  = sleep_q ? s_lvl : (lvl_q & ~led_m) | (led_v & led_m);
	wire [11:0] pul_d  = sleep_q ? s_pull & ~s_dir : n_pull & ~dir_q & ~ana & ~led_m;
	// the gate is open only while all three synchronised mode pins read high, whatever we drive
	wire        dbg_ok = &mode_s;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{io_out, io_oe, io_pull, sleeping, mode_out, mode_oe} <= '0;
			{rf_pan, rf_short, rf_long, rf_use_long, rf_channel} <= '0;
			{rf_power, rf_ack_en, rf_rx_all, adc_ref, adc_res, adc_avg} <= '0;
		end else begin
			io_out      <= out_d;
			io_oe       <= oe_d;
			io_pull     <= pul_d;
			sleeping    <= sleep_q;
			mode_oe     <= dbg_ok ? cfg_q[O_DBG][2:0] : 3'h0;
			mode_out    <= {rf_busy_q, !u_idle, rbusy_q};
			rf_pan      <= pan;
			rf_short    <= shrt;
			rf_long     <= {cfg_q[O_LONG+7], cfg_q[O_LONG+6], cfg_q[O_LONG+5],
			                cfg_q[O_LONG+4], cfg_q[O_LONG+3], cfg_q[O_LONG+2],
			                cfg_q[O_LONG+1], cfg_q[O_LONG]};
			rf_use_long <= shrt == SH_LONG;
			rf_channel  <= cfg_q[O_CHAN];
			rf_power    <= cfg_q[O_PWR][4:0];
			rf_ack_en   <= acken;
			rf_rx_all   <= rxall;
			adc_ref     <= cfg_q[O_ADC];
			adc_res     <= cfg_q[O_ADC+1];
			adc_avg     <= cfg_q[O_ADC+2];
		end
	end
endmodule : hscp_top

// ==== verification/hscp_checker.sv ====
// assertions on the parser's ports
`timescale 1ns/10ps
module hscp_checker (
	// watched signals
	input wire logic        hclk, hresetn, nvm_req, nvm_we, nvm_ack,
	input wire logic        rf_use_long, rf_rx_all, rf_tx_req,
	input wire logic [5:0]  nvm_addr,
	input wire logic [7:0]  nvm_wdata,
	input wire logic [15:0] rf_short,
	input wire logic [2:0]  mode_in, mode_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	load_start_a: assert property ($rose(hresetn) |-> ##[1:3] (nvm_req && !nvm_we && nvm_addr == 6'h00))
		else $error("load did not start at address zero");
	nvm_hold_a: assert property (nvm_req && !nvm_ack |=> nvm_req)
		else $error("store request dropped before answer");
	nvm_addr_a: assert property (nvm_req && !nvm_ack |=> $stable(nvm_addr) && $stable(nvm_we))
		else $error("store address moved while waiting");
	nvm_data_a: assert property (nvm_req && nvm_we && !nvm_ack |=> $stable(nvm_wdata))
		else $error("store write data moved while waiting");
	long_sel_a: assert property ($stable(rf_short) [*2] |-> rf_use_long == (rf_short == 16'hFFFE))
		else $error("long address select wrong");
	rxall_tx_a: assert property (!(rf_rx_all && rf_tx_req))
		else $error("send requested in receive all mode");
	tx_pulse_a: assert property (rf_tx_req |=> !rf_tx_req)
		else $error("send request longer than one cycle");
	debug_gate_a: assert property ((mode_in != 3'h7) [*6] |-> mode_oe == 3'h0)
		else $error("mode pins driven while pulled low");
endmodule : hscp_checker
bind hscp_top hscp_checker u_chk (.hclk, .hresetn, .nvm_req, .nvm_we, .nvm_ack, .rf_use_long,
	.rf_rx_all, .rf_tx_req, .nvm_addr, .nvm_wdata, .rf_short, .mode_in, .mode_oe);

// ==== verification/hscp_nvm_model.sv ====
// nonvolatile byte store answering the parser
`timescale 1ns/10ps
module hscp_nvm_model (
	// store port
	input wire logic       hclk, hresetn, nvm_req, nvm_we,
	input wire logic [5:0] nvm_addr,
	input wire logic [7:0] nvm_wdata,
	output logic     [7:0] nvm_rdata,
	output logic           nvm_ack
);
	logic [7:0] mem [64];
	logic       slow_q;
	int         nrd = 0;
	int         nwr = 0;
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		mem[12] = 8'h14;
	end
	// alternate latencies; data line toggles when not answering
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_q <= 1'b0;
			nvm_ack <= 1'b0;
			nvm_rdata <= 8'h00;
		end else begin
			slow_q <= ~slow_q;
			nvm_ack <= nvm_req && !nvm_ack && slow_q;
			nvm_rdata <= ~nvm_rdata;
			if (nvm_req && !nvm_ack && slow_q) begin
				nvm_rdata <= mem[nvm_addr];
				if (nvm_we) mem[nvm_addr] <= nvm_wdata;
				if (nvm_we) nwr <= nwr + 1;
				else nrd <= nrd + 1;
			end
		end
	end
endmodule : hscp_nvm_model

// ==== verification/host_serial_config_parser_tb.sv ====
// testbench for the host serial config parser
`timescale 1ns/10ps
module host_serial_config_parser_tb import hscp_pkg::*; ;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ser_rxd = 1, rf_tx_done = 0, rf_tx_acked = 0;
	logic rf_rx_valid = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, mode_in = 3'h7;
	logic [7:0] rf_rx_data = 0;
	logic [11:0] io_in = 12'hA5C;
	logic [15:0] rf_rx_pan = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	wire hreadyout, hresp, ser_txd, nvm_req, nvm_we, nvm_ack, rf_use_long, rf_ack_en, rf_rx_all;
	wire rf_tx_req, sleeping, adc_start;
	wire [5:0] nvm_addr;
	wire [7:0] nvm_wdata, nvm_rdata, rf_channel, adc_ref, adc_res, adc_avg;
	wire [15:0] rf_pan, rf_short;
	wire [31:0] hrdata;
	wire [63:0] rf_long;
	wire [4:0] rf_power;
	wire [11:0] io_out, io_oe, io_pull;
	wire [2:0] mode_out, mode_oe;
	wire hready = hreadyout;
	int fails = 0, total_checks = 0, cyc = 0;
	hscp_top #(.HB_CYCLES(200), .FLASH_CYCLES(20)) u_dut (.*);
	hscp_nvm_model u_nvm (.*);
	initial forever #20 hclk = ~hclk;
	always @(posedge hclk) if (++cyc == 100000) begin fails++; report_and_stop(); end
	task automatic chk(input logic [63:0] s, e);
		total_checks++;
		if (s !== e) begin fails++; $display("CHECK FAILED %0t saw %h want %h", $time, s, e); end
	endtask : chk
	task automatic ahb(input logic w, input logic [31:0] a, d);
		hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0; htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic wait_load();
		repeat (4) @(posedge hclk);
		do ahb(0, A_STAT, 0); while (rd[0] !== 1'b0);
	endtask : wait_load
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) for (int b = 0; b < 10; b++) begin
			ser_rxd <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : q[i][b-1];
			repeat (DIV_DEF) @(posedge hclk);
		end
	endtask : send
	task automatic expect_rx(input logic [7:0] q[$]);
		logic [7:0] v;
		foreach (q[i]) begin
			for (int k = 0; k < 40000 && ser_txd !== 1'b0; k++) @(posedge hclk);
			repeat (DIV_DEF / 2) @(posedge hclk);
			for (int b = 0; b < 8; b++) begin repeat (DIV_DEF) @(posedge hclk); v[b] = ser_txd; end
			repeat (DIV_DEF) @(posedge hclk);
			chk(v, q[i]);
		end
	endtask : expect_rx
	task automatic t_regs();
		ahb(1, A_CTRL, 1); repeat (2) @(posedge hclk); chk(sleeping, 1);
		ahb(1, A_CTRL, 0); ahb(0, 32'h20, 0); chk(rd, 0);
		ahb(0, A_IOIN, 0); chk(rd[11:0], 12'hA5C);
		mode_in <= 3'h6; ahb(1, A_RF, 1); repeat (8) @(posedge hclk);
		ahb(0, A_RF, 0); chk(rd[0], 1);
		rf_tx_done <= 1; @(posedge hclk); rf_tx_done <= 0; mode_in <= 3'h7;
		repeat (3) @(posedge hclk); ahb(0, A_RF, 0); chk(rd[0], 0);
	endtask : t_regs
	task automatic t_frames();
		// pan bytes overflow the sum, so the wrap is exercised
		fork
			send('{8'h07, SOF, 8'h07, T_PAN, 8'hF4, 8'hFF, 8'hFC, EOF});
			expect_rx('{8'h05, SOF, 8'h05, 8'h81, 8'h87, EOF});
		join
		chk(rf_pan, 16'hFFF4); chk(u_nvm.nwr, 0);
		fork
			send('{8'h05, SOF, 8'h05, T_SAVE, 8'h17, EOF});
			expect_rx('{8'h05, SOF, 8'h05, 8'h91, 8'h97, EOF});
		join
		chk(u_nvm.nwr, 36); chk({u_nvm.mem[1], u_nvm.mem[0]}, 16'hFFF4);
		send('{8'h06, SOF, 8'h06, T_CHAN, 8'h0B, 8'h00, EOF});
		ahb(0, A_STAT, 0); chk(rd[23:16], 1); chk(rf_channel, 8'h14);
		chk(rd[15:8], 2);
		// foreign network first; a wrongly taken one would be sent first
		rf_rx_pan <= 16'h0001; rf_rx_data <= 8'hA5; rf_rx_valid <= 1; @(posedge hclk);
		rf_rx_pan <= 16'hFFF4; rf_rx_data <= 8'h5A; @(posedge hclk); rf_rx_valid <= 0;
		expect_rx('{8'h06, SOF, 8'h06, T_RFRX, 8'h5A, 8'hF6, EOF});
	endtask : t_frames
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		wait_load(); chk(rf_channel, 8'h14); chk(u_nvm.nrd, 36);
		t_regs();
		t_frames();
		u_nvm.mem[12] = 8'h19;
		u_nvm.mem[32] = 8'h07;
		ahb(1, A_CTRL, 2); wait_load(); chk(rf_channel, 8'h19);
		chk(mode_oe, 3'h7);
		mode_in <= 3'h6; repeat (8) @(posedge hclk); chk(mode_oe, 3'h0);
		report_and_stop();
	end
endmodule : host_serial_config_parser_tb
